// ### gpx_consts.vh
// Constants for the eight-pin general-purpose port with masked data access.
// Assumes inclusion by gpx_port.v only; holds definitions and no logic.

`ifndef GPX_CONSTS_VH
`define GPX_CONSTS_VH

`define GPX_ADR_W 12
`define GPX_PINS 8

`define GPX_OFF_DIR 12'h400
`define GPX_OFF_SENSE 12'h404
`define GPX_OFF_BOTH 12'h408
`define GPX_OFF_POL 12'h40c
`define GPX_OFF_UNMASK 12'h410
`define GPX_OFF_RAW 12'h414
`define GPX_OFF_MIS 12'h418
`define GPX_OFF_CLR 12'h41c
`define GPX_OFF_ALT 12'h420
`define GPX_OFF_DEN 12'h51c

`define GPX_RST_ZERO 8'h00
`define GPX_RST_DEN 8'hff
`define GPX_RST_ALT 8'h00

`define GPX_MASK_LSB 2
`define GPX_MASK_MSB 9
`define GPX_DATA_TOP 2'b00

`endif

// ### gpx_port.v
// One eight-pin general-purpose port with masked data access and pin interrupts.
// Assumes a classic Wishbone master on clk, pads reached through an external
// buffer that honours padOeB, and an alternate peripheral on the same clock.
//
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ps
`include "gpx_consts.vh"

module gpx_port #(
  parameter [7:0] ALT_RESET = `GPX_RST_ALT,
  parameter integer TRIG_PIN = 4,
  parameter TRIG_EN = 1'b0
) (
  // Clock and reset.
  input wire clk,
  input wire rst_b,
  // Wishbone slave.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // Pads.
  input wire [7:0] padIn,
  output reg [7:0] padOut,
  output reg [7:0] padOeB,
  // Alternate peripheral.
  input wire [7:0] altOut,
  input wire [7:0] altDrive,
  output reg [7:0] altIn,
  // Events.
  output reg portIrq,
  output reg convTrigger
);

  // Merge new bits into old ones under a per-bit select.
  function [7:0] merge;
    input [7:0] old;
    input [7:0] val;
    input [7:0] sel;
    begin
      merge = (old & ~sel) | (val & sel);
    end
  endfunction

  // Decode of one control register word.
  function hit;
    input [11:0] adr;
    input [11:0] off;
    begin
      hit = (adr[11:2] == off[11:2]);
    end
  endfunction

  reg rstMeta;
  reg rstSync;

  reg [7:0] pinMeta;
  reg [7:0] pinSync;
  reg [7:0] pinPrev;

  reg [7:0] portData;
  reg [7:0] pinDir;
  reg [7:0] irqSense;
  reg [7:0] irqBoth;
  reg [7:0] irqPol;
  reg [7:0] irqUnmask;
  reg [7:0] edgeLatch;
  reg [7:0] rawIrq;
  reg [7:0] altSel;
  reg [7:0] digEn;
  reg [1:0] settle;

  wire busReq;
  wire busWr;
  wire wrDir;
  wire wrSense;
  wire wrBoth;
  wire wrPol;
  wire wrUnmask;
  wire wrAlt;
  wire wrDen;
  wire edgeOk;
  wire lowLane;
  wire dataSpace;
  wire [7:0] addrMask;
  wire [7:0] wrByte;
  wire [7:0] pinIn;
  wire [7:0] rise;
  wire [7:0] fall;
  wire [7:0] edgeHit;
  wire [7:0] levelHit;
  wire [7:0] clrBits;
  wire [7:0] next_edgeLatch;
  wire [7:0] next_raw;
  wire [7:0] next_mis;
  wire [7:0] next_portData;
  reg [7:0] next_rd;

  // Both reset sources arrive on rst_b; release is synchronised.
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  assign busReq = wb_cyc_i & wb_stb_i;
  // A write lands on the edge where the master samples ack high.
  assign busWr = busReq & wb_we_i & wb_ack_o;
  assign lowLane = wb_sel_i[0];
  assign wrByte = wb_dat_i[7:0];
  assign dataSpace = (wb_adr_i[11:10] == `GPX_DATA_TOP);
  assign addrMask = wb_adr_i[`GPX_MASK_MSB:`GPX_MASK_LSB];

  // One strobe per writable control register except the clear register, whose write decode sits with clrBits.
  assign wrDir = busWr & lowLane & hit(wb_adr_i, `GPX_OFF_DIR);
  assign wrSense = busWr & lowLane & hit(wb_adr_i, `GPX_OFF_SENSE);
  assign wrBoth = busWr & lowLane & hit(wb_adr_i, `GPX_OFF_BOTH);
  assign wrPol = busWr & lowLane & hit(wb_adr_i, `GPX_OFF_POL);
  assign wrUnmask = busWr & lowLane & hit(wb_adr_i, `GPX_OFF_UNMASK);
  assign wrAlt = busWr & lowLane & hit(wb_adr_i, `GPX_OFF_ALT);
  assign wrDen = busWr & lowLane & hit(wb_adr_i, `GPX_OFF_DEN);

  // Pin levels cross into clk before anything reads them.
  always @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      pinMeta <= `GPX_RST_ZERO;
      pinSync <= `GPX_RST_ZERO;
      pinPrev <= `GPX_RST_ZERO;
    end else begin
      pinMeta <= padIn;
      pinSync <= pinMeta;
      pinPrev <= pinIn;
    end
  end

  // A disabled digital path reads low, leaving the pad free for analog use.
  assign pinIn = pinSync & digEn;

  assign rise = pinIn & ~pinPrev;
  assign fall = ~pinIn & pinPrev;

  // The pin history resets low, so an idle-high pad would look like a rising
  // edge right after reset. Edges count only once the history holds real levels.
  always @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      settle <= 2'b00;
    end else if (settle != 2'b11) begin
      settle <= settle + 2'b01;
    end
  end

  assign edgeOk = (settle == 2'b11);

  // Edge detection per pin.
  assign edgeHit = {8{edgeOk}} & ~irqSense & (irqBoth & (rise | fall) |
                   ~irqBoth & ((irqPol & rise) | (~irqPol & fall)));

  // Level conditions follow the pin and are not latched.
  assign levelHit = irqSense & ((irqPol & pinIn) | (~irqPol & ~pinIn));

  assign clrBits = (busWr && lowLane && hit(wb_adr_i, `GPX_OFF_CLR)) ? wrByte
                   : `GPX_RST_ZERO;

  // A new edge in the clearing cycle wins over the clear.
  assign next_edgeLatch = (edgeLatch & ~clrBits) | edgeHit;

  assign next_raw = next_edgeLatch | levelHit;
  assign next_mis = next_raw & irqUnmask;

  // Inputs capture the pin; masked writes touch only output bits.
  assign next_portData = (busWr && lowLane && dataSpace) ?
                         merge(merge(portData, wrByte, addrMask & pinDir),
                               pinIn, ~pinDir) :
                         merge(portData, pinIn, ~pinDir);

  // Direction: a one hands the pad to the port's stored data, unless altSel gives it to the peripheral.
  always @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      pinDir <= `GPX_RST_ZERO;
    end else if (wrDir) begin
      pinDir <= wrByte;
    end
  end

  // Alternate select: the reset value differs per port for the test pins.
  always @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      altSel <= ALT_RESET;
    end else if (wrAlt) begin
      altSel <= wrByte;
    end
  end

  // Unmasked pins may fire on the next three writes; software masks first.
  always @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      irqSense <= `GPX_RST_ZERO;
    end else if (wrSense) begin
      irqSense <= wrByte;
    end
  end

  always @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      irqBoth <= `GPX_RST_ZERO;
    end else if (wrBoth) begin
      irqBoth <= wrByte;
    end
  end

  always @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      irqPol <= `GPX_RST_ZERO;
    end else if (wrPol) begin
      irqPol <= wrByte;
    end
  end

  // The mask only gates the output; raw status keeps updating regardless.
  always @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      irqUnmask <= `GPX_RST_ZERO;
    end else if (wrUnmask) begin
      irqUnmask <= wrByte;
    end
  end

  // Digital enable comes up set so every pin reads as a logic input.
  always @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      digEn <= `GPX_RST_DEN;
    end else if (wrDen) begin
      digEn <= wrByte;
    end
  end

  // Data and interrupt state.
  always @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      portData <= `GPX_RST_ZERO;
      edgeLatch <= `GPX_RST_ZERO;
      rawIrq <= `GPX_RST_ZERO;
      portIrq <= 1'b0;
      convTrigger <= 1'b0;
    end else begin
      portData <= next_portData;
      edgeLatch <= next_edgeLatch;
      rawIrq <= next_raw;
      portIrq <= |next_mis;
      convTrigger <= TRIG_EN & next_mis[TRIG_PIN];
    end
  end

  // Pads: output pins drive stored data unless the peripheral owns them.
  always @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      padOut <= `GPX_RST_ZERO;
      padOeB <= 8'hff;
    end else begin
      padOut <= merge(portData, altOut, altSel);
      padOeB <= ~merge(pinDir, altDrive, altSel);
    end
  end

  // The peripheral sees the same gated pin level as the port itself.
  always @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      altIn <= `GPX_RST_ZERO;
    end else begin
      altIn <= pinIn;
    end
  end

  // Read mux; reads have no side effects.
  always @* begin
    next_rd = `GPX_RST_ZERO;
    if (dataSpace) begin
      next_rd = portData & addrMask;
    end else if (hit(wb_adr_i, `GPX_OFF_DIR)) begin
      next_rd = pinDir;
    end else if (hit(wb_adr_i, `GPX_OFF_SENSE)) begin
      next_rd = irqSense;
    end else if (hit(wb_adr_i, `GPX_OFF_BOTH)) begin
      next_rd = irqBoth;
    end else if (hit(wb_adr_i, `GPX_OFF_POL)) begin
      next_rd = irqPol;
    end else if (hit(wb_adr_i, `GPX_OFF_UNMASK)) begin
      next_rd = irqUnmask;
    end else if (hit(wb_adr_i, `GPX_OFF_RAW)) begin
      next_rd = rawIrq;
    end else if (hit(wb_adr_i, `GPX_OFF_MIS)) begin
      next_rd = rawIrq & irqUnmask;
    end else if (hit(wb_adr_i, `GPX_OFF_ALT)) begin
      next_rd = altSel;
    end else if (hit(wb_adr_i, `GPX_OFF_DEN)) begin
      next_rd = digEn;
    end
  end

  // One wait state: data is captured and ack is raised on the same first edge.
  always @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= busReq & ~wb_ack_o;
      if (busReq && !wb_ack_o) begin
        wb_dat_o <= {24'h000000, next_rd};
      end
    end
  end

endmodule

// ### gpx_pin_model.sv
// Outside circuitry on the eight pads of the port.
// Assumes the bench sets the level that outside sources would put on each pad.
`timescale 1ns/1ps
module gpx_pin_model (
  // Port side.
  input wire logic [7:0] padOut,
  input wire logic [7:0] padOeB,
  // Outside sources.
  input wire logic [7:0] extLevel,
  output logic [7:0] padIn
);
  // A pad the port drives shows its value; the outside source yields to it.
  assign padIn = (~padOeB & padOut) | (padOeB & extLevel);
endmodule

// ### gpx_port_monitor.sv
// Concurrent checks on the port's bus answer, pads and event outputs.
// Assumes one clock domain and that it is bound into gpx_port.
`timescale 1ns/1ps
module gpx_port_monitor (
  // Clock and reset.
  input wire clk,
  input wire rst_b,
  // Bus.
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // Pads and events.
  input wire [7:0] padIn,
  input wire [7:0] padOeB,
  input wire portIrq,
  input wire convTrigger
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  ack_follow_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing after request");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  upper_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("read data upper bits set");
  dat_hold_a: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
    else $error("read data moved without request");
  reset_safe_a: assert property ($rose(rst_b) |-> padOeB == 8'hff && !portIrq && !convTrigger)
    else $error("pads or events active in reset");
  trig_irq_a: assert property (convTrigger |-> portIrq)
    else $error("trigger without port interrupt");
  // Six quiet cycles cover the pad synchroniser and edge detector latency.
  irq_quiet_a: assert property ((!wb_cyc_i && $stable(padIn)) [*6] |-> $stable(portIrq))
    else $error("interrupt moved with no cause");
endmodule

bind gpx_port gpx_port_monitor u_mon (.clk(clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .padIn(padIn),
  .padOeB(padOeB), .portIrq(portIrq), .convTrigger(convTrigger));

// ### gpx_testbench.sv
// Self-checking bench for the port: bus, masked data, pin events, alternate use.
// Assumes gpx_pin_model on the pads and the monitor bound into the port.
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rstB = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, portIrq, convTrigger;
  logic [11:0] adr = 12'h000;
  logic [31:0] wdat = 32'h0, rdat;
  logic [7:0] ext = 8'ha0, altOut = 8'h00, altDrive = 8'h00, padIn, padOut, padOeB, altIn;
  int nErrors = 0, nTests = 0;
  always #5 clk = ~clk;
  gpx_port #(.ALT_RESET(8'h80), .TRIG_EN(1'b1)) u_gpx_port (.clk(clk), .rst_b(rstB),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .padIn(padIn), .padOut(padOut),
    .padOeB(padOeB), .altOut(altOut), .altDrive(altDrive), .altIn(altIn),
    .portIrq(portIrq), .convTrigger(convTrigger));
  gpx_pin_model u_gpx_pin_model (.padOut(padOut), .padOeB(padOeB), .extLevel(ext),
    .padIn(padIn));
  task automatic endOfTest();
    $display("tests %0d errors %0d", nTests, nErrors);
    if (nErrors == 0 && nTests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    nTests++;
    if (g !== e) begin
      nErrors++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d,
    output logic [7:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] q;
    wb(1'b0, a, 8'h00, q);
    chk($sformatf("rd %h", a), e, q);
  endtask
  task automatic tReset();
    chk("oe", 8'hff, padOeB);
    for (int i = 0; i < 5; i++) rd(12'h400 + 12'(4 * i), 8'h00);
    rd(12'h420, 8'h80);
    rd(12'h51c, 8'hff);
    rd(12'h600, 8'h00);
  endtask
  task automatic tData();
    wr(12'h420, 8'h00);
    wr(12'h400, 8'h0f);
    wr(12'h098, 8'heb);
    wr(12'h000, 8'hff);
    repeat (2) @(posedge clk);
    chk("out", 8'h02, padOut & 8'h0f);
    chk("oe", 8'hf0, padOeB);
    rd(12'h3fc, 8'ha2);
    rd(12'h0c4, 8'h20);
  endtask
  task automatic tIrq();
    wr(12'h40c, 8'h10);
    wr(12'h41c, 8'hff);
    // Unmask last so the setup writes cannot leave a false event behind.
    wr(12'h410, 8'h10);
    ext <= 8'hb0;
    repeat (8) @(posedge clk);
    chk("irq", 8'h01, {7'h0, portIrq});
    chk("trig", 8'h01, {7'h0, convTrigger});
    rd(12'h418, 8'h10);
    ext <= 8'ha0;
    repeat (8) @(posedge clk);
    ext <= 8'hb0;
    wr(12'h41c, 8'h00);
    repeat (8) @(posedge clk);
    chk("held", 8'h01, {7'h0, portIrq});
    wr(12'h410, 8'h00);
    repeat (4) @(posedge clk);
    chk("masked", 8'h00, {7'h0, portIrq | convTrigger});
    rd(12'h414, 8'h10);
    rd(12'h418, 8'h00);
    wr(12'h41c, 8'h10);
    rd(12'h414, 8'h00);
  endtask
  task automatic tEdges();
    wr(12'h408, 8'h40);
    wr(12'h404, 8'h20);
    wr(12'h41c, 8'hff);
    rd(12'h414, 8'h00);
    wr(12'h410, 8'h60);
    for (int i = 0; i < 2; i++) begin
      ext <= ext ^ 8'h40;
      repeat (8) @(posedge clk);
      rd(12'h414, 8'h40);
      wr(12'h41c, 8'h40);
    end
    ext <= 8'h90;
    repeat (8) @(posedge clk);
    rd(12'h414, 8'h20);
    chk("level", 8'h01, {7'h0, portIrq});
    ext <= 8'hb0;
    repeat (8) @(posedge clk);
    rd(12'h414, 8'h00);
  endtask
  task automatic tAlt();
    ext <= 8'hb8;
    wr(12'h420, 8'h08);
    wr(12'h51c, 8'hf7);
    repeat (8) @(posedge clk);
    chk("alt oe", 8'hf8, padOeB);
    chk("alt in", 8'hb2, altIn);
    altOut <= 8'h08;
    altDrive <= 8'h08;
    repeat (4) @(posedge clk);
    chk("alt oe", 8'hf0, padOeB);
    chk("alt out", 8'h0a, padOut & 8'h0f);
  endtask
  task automatic tReRun();
    rstB <= 1'b0;
    @(posedge clk);
    rstB <= 1'b1;
    repeat (3) @(posedge clk);
    chk("oe", 8'hff, padOeB);
    rd(12'h420, 8'h80);
    rd(12'h400, 8'h00);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rstB <= 1'b1;
    repeat (3) @(posedge clk);
    tReset();
    tData();
    tIrq();
    tEdges();
    tAlt();
    tReRun();
    endOfTest();
  end
  initial begin
    repeat (20000) @(posedge clk);
    nErrors++;
    endOfTest();
  end
endmodule
